// >>> pkg/cchp_pkg.sv
// Purpose: shared constants and types of the crt controller host bus port
// Assumes: one clock, registers reached through an indirect address register
// Notes: widths, offsets, bit positions and the reset values of status, control and address registers live here
package cchp_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned MEM_AW = 7;
  localparam int unsigned STAT_W = 8;
  localparam int unsigned SYNC_W = 22;
  localparam int unsigned GAI_W = 3;

  // ----------------------------------------------------------------
  // status register bit positions and value after reset
  // ----------------------------------------------------------------
  localparam int unsigned ST_WQ_READY = 0;
  localparam int unsigned ST_WQ_EMPTY = 1;
  localparam int unsigned ST_CMD_END = 5;
  localparam logic [STAT_W-1:0] STAT_RST = 8'h23;

  // ----------------------------------------------------------------
  // control register numbers, fields and values after reset
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CCR_IDX = 8'h02;
  localparam logic [ADDR_W-1:0] OMR_IDX = 8'h04;
  localparam int unsigned CCR_ABORT = 15;
  localparam int unsigned CCR_CDM = 12;
  localparam int unsigned CCR_DDM = 11;
  localparam int unsigned CCR_BURST = 10;
  localparam logic [DATA_W-1:0] CCR_RST = 16'h8000;
  localparam int unsigned OMR_MS = 15;
  localparam int unsigned OMR_RUN = 14;
  localparam int unsigned OMR_GAI_LO = 0;
  localparam logic [1:0] OMR_CTL_RST = 2'h0;

  // ----------------------------------------------------------------
  // address register and data bus constants
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] AR_RST = 8'h00;
  localparam int unsigned AR_AUTO_BIT = 7;
  localparam logic [ADDR_W-1:0] AR_INC8 = 8'h01;
  localparam logic [ADDR_W-1:0] AR_INC16 = 8'h02;
  localparam logic [7:0] LANE_HI_FILL = 8'hff;

  // ----------------------------------------------------------------
  // positions of pins in the synchroniser vector
  // ----------------------------------------------------------------
  localparam int unsigned SY_CS = 0;
  localparam int unsigned SY_DMA_GRANT_IN = 1;
  localparam int unsigned SY_RS = 2;
  localparam int unsigned SY_RW = 3;
  localparam int unsigned SY_DONE = 4;
  localparam int unsigned SY_RST = 5;
  localparam int unsigned SY_DATA = 6;

  // host cycle states
  typedef enum logic [1:0] {ST_IDLE, ST_RD_WAIT, ST_RD_ACK, ST_WR_ACK} cchp_state_e;
endpackage

// >>> pkg/cchp_mem_if.sv
// Purpose: port between host port logic and control register store
// Assumes: one clock, read data registered inside the store
// Notes: byte enables bit 1 high lane, bit 0 low lane
`timescale 1ns/1ps
interface cchp_mem_if;
  logic [cchp_pkg::MEM_AW-1:0] addr;
  logic [cchp_pkg::DATA_W-1:0] wdata;
  logic [1:0] be;
  logic we;
  logic [cchp_pkg::DATA_W-1:0] rdata;
  modport ctrl (output addr, output wdata, output be, output we, input rdata);
  modport mem (input addr, input wdata, input be, input we, output rdata);
endinterface

// >>> verilog/cchp_sync.sv
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to core_clk_in
// Notes: first stage is read by the second stage only
`timescale 1ns/1ps
module cchp_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // pins and synchronised copy
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // pins idle high, so reset to ones
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      meta_q <= {W{1'b1}};
      sync_q <= {W{1'b1}};
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule // cchp_sync

// >>> verilog/cchp_reg_mem.sv
// Purpose: store for the control registers that reset leaves alone
// Assumes: one write port and one read port on the same address
// Notes: no reset on purpose, contents survive the reset pin
`timescale 1ns/1ps
module cchp_reg_mem (
  // clock
  input wire logic core_clk_in,
  // access port
  cchp_mem_if.mem port
);
  logic [cchp_pkg::DATA_W-1:0] mem_q [0:(1<<cchp_pkg::MEM_AW)-1];
  logic [cchp_pkg::DATA_W-1:0] rdata_q;

  // byte lane writes, registered read
  always_ff @(posedge core_clk_in)
  begin
    if (port.we && port.be[1])
    begin
      mem_q[port.addr][15:8] <= port.wdata[15:8];
    end
    if (port.we && port.be[0])
    begin
      mem_q[port.addr][7:0] <= port.wdata[7:0];
    end
    rdata_q <= mem_q[port.addr];
  end

  assign port.rdata = rdata_q;
endmodule // cchp_reg_mem

// >>> verilog/cchp_host_port.sv
// Purpose: host bus port of a graphics crt controller
// Assumes: pins asynchronous to core_clk_in; core signals on core_clk_in
// Notes: two-way and open-drain pins are split into value and active-low enable
`timescale 1ns/1ps
module cchp_host_port (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // host bus pins
  input wire logic reset_in_n,
  input wire logic chip_select_n_in,
  input wire logic register_select_in,
  input wire logic read_write_in,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_lo_oe_n_out,
  output logic data_hi_oe_n_out,
  output logic transfer_ack_oe_n_out,
  output logic irq_oe_n_out,
  // dma controller pins
  input wire logic dma_grant_n_in,
  input wire logic dma_done_n_in,
  output logic dma_request_n_out,
  // drawing and display core
  input wire logic [7:0] status_event_in,
  input wire logic data_xfer_cmd_in,
  input wire logic dma_ready_in,
  input wire logic core_hsync_n_in,
  input wire logic [7:0] refresh_addr_in,
  output logic halt_out,
  output logic abort_out,
  output logic display_run_out,
  output logic master_slave_out,
  output logic bus16_out,
  output logic [15:0] command_control_out,
  // frame memory pins
  output logic [15:0] frame_mem_addr_data_out,
  output logic frame_mem_oe_n_out,
  output logic hsync_n_out
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // word hit on a register number, lane bit ignored
  function automatic logic word_hit(input logic [7:0] ar, input logic [7:0] idx);
    word_hit = (ar[7:1] == idx[7:1]);
  endfunction

  // merge host data into a word; byte bus picks lane by address bit 0
  function automatic logic [15:0] merge_wr(input logic [15:0] old, input logic [15:0] wd,
                                           input logic b16, input logic odd);
    merge_wr = b16 ? wd : (odd ? {old[15:8], wd[7:0]} : {wd[7:0], old[7:0]});
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [cchp_pkg::SYNC_W-1:0] pins_s;
  logic cs_s, dma_grant_in_s, rs_s, rw_s, done_s, rst_pin;
  logic [15:0] wd_s;

  cchp_sync #(.W(cchp_pkg::SYNC_W)) u_sync (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in({data_in, reset_in_n, dma_done_n_in, read_write_in, register_select_in,
               dma_grant_n_in, chip_select_n_in}),
    .sync_out(pins_s)
  );

  assign cs_s = pins_s[cchp_pkg::SY_CS];
  assign dma_grant_in_s = pins_s[cchp_pkg::SY_DMA_GRANT_IN];
  assign rs_s = pins_s[cchp_pkg::SY_RS];
  assign rw_s = pins_s[cchp_pkg::SY_RW];
  assign done_s = pins_s[cchp_pkg::SY_DONE];
  assign rst_pin = ~pins_s[cchp_pkg::SY_RST];
  assign wd_s = pins_s[cchp_pkg::SY_DATA +: 16];

  // ----------------------------------------------------------------
  // register store
  // ----------------------------------------------------------------
  cchp_mem_if mem_bus ();

  cchp_reg_mem u_mem (
    .core_clk_in(core_clk_in),
    .port(mem_bus.mem)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cchp_pkg::cchp_state_e state_q, state_d;
  logic rs_q, rs_d;
  logic [7:0] ar_q, ar_d;
  logic [7:0] status_q, status_d;
  logic [7:0] clr_q, clr_d;
  logic [15:0] ccr_q, ccr_d;
  logic [1:0] omr_ctl_q, omr_ctl_d;
  logic [13:0] omr_rest_q, omr_rest_d;
  logic [15:0] dout_q, dout_d;
  logic bus16_q, bus16_d;
  logic strap_q, strap_d;
  logic steal_q, steal_d;
  logic dma_request_out_n_q, dma_request_out_n_d;
  logic irq_n_q, irq_n_d;
  logic halt_q, halt_d;
  logic sel, is_read, acc_end, reg_wr, auto_inc;
  logic [15:0] omr_w, rd_word, wr_word;
  logic cmd_act, data_act, want, burst;

  assign omr_w = {omr_ctl_q, omr_rest_q};
  assign sel = ~cs_s | ~dma_grant_in_s;
  assign acc_end = ~sel && (state_q == cchp_pkg::ST_RD_ACK || state_q == cchp_pkg::ST_WR_ACK);
  assign reg_wr = acc_end && (state_q == cchp_pkg::ST_WR_ACK) && rs_q;
  // advance only in the upper register range
  assign auto_inc = acc_end && rs_q && ar_q[cchp_pkg::AR_AUTO_BIT];
  assign is_read = dma_grant_in_s ? rw_s : ~rw_s;

  always_comb
  begin
    if (word_hit(ar_q, cchp_pkg::CCR_IDX))
    begin
      rd_word = ccr_q;
    end
    else if (word_hit(ar_q, cchp_pkg::OMR_IDX))
    begin
      rd_word = omr_w;
    end
    else
    begin
      rd_word = mem_bus.rdata;
    end
  end

  // ----------------------------------------------------------------
  // store access
  // ----------------------------------------------------------------
  always_comb
  begin
    mem_bus.addr = ar_q[7:1];
    mem_bus.wdata = bus16_q ? wd_s : {wd_s[7:0], wd_s[7:0]};
    mem_bus.be = bus16_q ? 2'h3 : (ar_q[0] ? 2'h1 : 2'h2);
    mem_bus.we = reg_wr && !word_hit(ar_q, cchp_pkg::CCR_IDX) && !word_hit(ar_q, cchp_pkg::OMR_IDX);
  end

  // ----------------------------------------------------------------
  // host cycle and registers
  // ----------------------------------------------------------------
  // host cycle sequencing, register next values
  always_comb
  begin
    state_d = state_q;
    rs_d = rs_q;
    ar_d = ar_q;
    dout_d = dout_q;
    clr_d = clr_q;
    ccr_d = ccr_q;
    omr_ctl_d = omr_ctl_q;
    omr_rest_d = omr_rest_q;
    wr_word = 16'h0000;
    unique case (state_q)
      cchp_pkg::ST_IDLE:
      begin
        // select and direction taken at select edge
        if (sel)
        begin
          rs_d = rs_s;
          state_d = is_read ? cchp_pkg::ST_RD_WAIT : cchp_pkg::ST_WR_ACK;
        end
      end
      cchp_pkg::ST_RD_WAIT:
      begin
        if (!rs_q)
        begin
          dout_d = {8'h00, status_q};
          clr_d = status_q;
        end
        else if (bus16_q)
        begin
          dout_d = rd_word;
          clr_d = 8'h00;
        end
        else
        begin
          dout_d = {8'h00, ar_q[0] ? rd_word[7:0] : rd_word[15:8]};
          clr_d = 8'h00;
        end
        state_d = cchp_pkg::ST_RD_ACK;
      end
      cchp_pkg::ST_RD_ACK,
      cchp_pkg::ST_WR_ACK:
      begin
        if (!sel)
        begin
          state_d = cchp_pkg::ST_IDLE;
          clr_d = 8'h00;
        end
      end
    endcase
    // upper lanes high on byte bus, also right after a width change
    if (!bus16_d)
    begin
      dout_d[15:8] = cchp_pkg::LANE_HI_FILL;
    end
    // select low write loads the address
    if (acc_end && state_q == cchp_pkg::ST_WR_ACK && !rs_q)
    begin
      ar_d = wd_s[7:0];
    end
    // step one on byte bus, two on word bus
    if (auto_inc)
    begin
      ar_d = ar_q + (bus16_q ? cchp_pkg::AR_INC16 : cchp_pkg::AR_INC8);
    end
    // write data is the level sampled together with select going high
    if (reg_wr && word_hit(ar_q, cchp_pkg::CCR_IDX))
    begin
      ccr_d = merge_wr(ccr_q, wd_s, bus16_q, ar_q[0]);
    end
    if (reg_wr && word_hit(ar_q, cchp_pkg::OMR_IDX))
    begin
      wr_word = merge_wr(omr_w, wd_s, bus16_q, ar_q[0]);
      omr_ctl_d = wr_word[15:14];
      omr_rest_d = wr_word[13:0];
    end
    // done pin low ends command dma
    if (!done_s)
    begin
      ccr_d[cchp_pkg::CCR_CDM] = 1'b0;
    end
    // reset pin: abort set, rest cleared
    if (rst_pin)
    begin
      ccr_d = cchp_pkg::CCR_RST;
      state_d = cchp_pkg::ST_IDLE;
    end
    // reset pin clears master and run only
    if (rst_pin)
    begin
      omr_ctl_d = cchp_pkg::OMR_CTL_RST;
    end
  end

  // status, strap, dma request, interrupt, halt next values
  always_comb
  begin
    // events win over the read clear
    status_d = (status_q & ~(acc_end ? clr_q : 8'h00)) | status_event_in;
    if (rst_pin)
    begin
      status_d = cchp_pkg::STAT_RST;
    end
    // width sampled while reset is active
    strap_d = 1'b0;
    bus16_d = (rst_pin || strap_q) ? dma_grant_in_s : bus16_q;
    // data dma while command runs, or command dma
    cmd_act = ccr_q[cchp_pkg::CCR_CDM];
    data_act = ccr_q[cchp_pkg::CCR_DDM] && data_xfer_cmd_in;
    want = (cmd_act || data_act) && dma_ready_in && !rst_pin;
    // burst only for data dma with burst bit
    burst = data_act && ccr_q[cchp_pkg::CCR_BURST] && !cmd_act;
    // steal: one request per grant, rearm after grant ends
    steal_d = !dma_grant_in_s || (steal_q && state_q != cchp_pkg::ST_IDLE);
    dma_request_out_n_d = !(want && (burst || (!steal_q && dma_grant_in_s)));
    irq_n_d = ~|(status_q & ccr_q[7:0]);
    halt_d = rst_pin;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // control state, constants on the asynchronous reset
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state_q <= cchp_pkg::ST_IDLE;
      rs_q <= 1'b0;
      ar_q <= cchp_pkg::AR_RST;
      dout_q <= 16'h0000;
      clr_q <= 8'h00;
      status_q <= cchp_pkg::STAT_RST;
      ccr_q <= cchp_pkg::CCR_RST;
      omr_ctl_q <= cchp_pkg::OMR_CTL_RST;
      bus16_q <= 1'b1;
      strap_q <= 1'b1;
      steal_q <= 1'b0;
      dma_request_out_n_q <= 1'b1;
      irq_n_q <= 1'b1;
      halt_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      rs_q <= rs_d;
      ar_q <= ar_d;
      dout_q <= dout_d;
      clr_q <= clr_d;
      status_q <= status_d;
      ccr_q <= ccr_d;
      omr_ctl_q <= omr_ctl_d;
      bus16_q <= bus16_d;
      strap_q <= strap_d;
      steal_q <= steal_d;
      dma_request_out_n_q <= dma_request_out_n_d;
      irq_n_q <= irq_n_d;
      halt_q <= halt_d;
    end
  end

  // mode bits that reset leaves alone, so no reset here
  always_ff @(posedge core_clk_in)
  begin
    omr_rest_q <= omr_rest_d;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // low lanes driven only while a read is answered
  assign data_out = dout_q;
  assign data_lo_oe_n_out = (state_q != cchp_pkg::ST_RD_ACK);
  // byte bus keeps upper lanes driven
  assign data_hi_oe_n_out = bus16_q ? (state_q != cchp_pkg::ST_RD_ACK) : 1'b0;
  // acknowledge pulled low until select ends
  assign transfer_ack_oe_n_out = !(state_q == cchp_pkg::ST_RD_ACK || state_q == cchp_pkg::ST_WR_ACK);
  assign irq_oe_n_out = irq_n_q;
  assign dma_request_n_out = dma_request_out_n_q;
  assign halt_out = halt_q;
  assign abort_out = ccr_q[cchp_pkg::CCR_ABORT];
  assign display_run_out = omr_ctl_q[cchp_pkg::OMR_RUN-14];
  assign master_slave_out = omr_ctl_q[cchp_pkg::OMR_MS-14];
  assign bus16_out = bus16_q;
  assign command_control_out = ccr_q;
  // refresh address shifted by step mode; frame bus driven until run
  assign frame_mem_addr_data_out = {8'h00, refresh_addr_in} << omr_rest_q[cchp_pkg::OMR_GAI_LO +: cchp_pkg::GAI_W];
  assign frame_mem_oe_n_out = omr_ctl_q[cchp_pkg::OMR_RUN-14];
  assign hsync_n_out = omr_ctl_q[cchp_pkg::OMR_RUN-14] ? core_hsync_n_in : 1'b0;
endmodule // cchp_host_port

// >>> verif/cchp_host_port_props.sv
// Purpose: port-level properties of the host bus port
// Assumes: one clock domain, sys_rst_in asynchronous
// Notes: sees only top ports; attached by the bind at the foot
`timescale 1ns/1ps
module cchp_host_port_props (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // host and dma pins
  input wire logic reset_in_n,
  input wire logic chip_select_n_in,
  input wire logic dma_grant_n_in,
  input wire logic dma_done_n_in,
  input wire logic data_xfer_cmd_in,
  input wire logic [15:0] data_out,
  input wire logic data_lo_oe_n_out,
  input wire logic data_hi_oe_n_out,
  input wire logic transfer_ack_oe_n_out,
  input wire logic irq_oe_n_out,
  input wire logic dma_request_n_out,
  // core and frame side
  input wire logic halt_out,
  input wire logic abort_out,
  input wire logic display_run_out,
  input wire logic master_slave_out,
  input wire logic bus16_out,
  input wire logic [15:0] command_control_out,
  input wire logic frame_mem_oe_n_out,
  input wire logic hsync_n_out
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  property p_hsync_hold;
    !display_run_out |-> !hsync_n_out;
  endproperty
  a_hsync_hold: assert property (p_hsync_hold) else $error("hsync not low before run");
  property p_frame_drive;
    !display_run_out |-> !frame_mem_oe_n_out;
  endproperty
  a_frame_drive: assert property (p_frame_drive) else $error("frame bus not driven before run");
  property p_read_drive;
    !data_lo_oe_n_out |-> !transfer_ack_oe_n_out;
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("data driven outside answer");
  property p_hi_lane;
    !bus16_out |-> !data_hi_oe_n_out && data_out[15:8] == 8'hff;
  endproperty
  a_hi_lane: assert property (p_hi_lane) else $error("upper lanes not driven high");
  property p_hi_follow;
    bus16_out |-> data_hi_oe_n_out == data_lo_oe_n_out;
  endproperty
  a_hi_follow: assert property (p_hi_follow) else $error("upper lane enable differs");
  property p_ack_cause;
    $fell(transfer_ack_oe_n_out) |-> $past(!chip_select_n_in || !dma_grant_n_in, 2);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without select");
  property p_ack_release;
    (chip_select_n_in && dma_grant_n_in) [*6] |-> transfer_ack_oe_n_out;
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("ack held while idle");
  property p_irq_mask;
    (command_control_out[7:0] == 8'h00) [*2] |-> irq_oe_n_out;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq with no enable");
  property p_reset_pin;
    (!reset_in_n) [*4] |=> halt_out && abort_out && !display_run_out && !master_slave_out
      && command_control_out == cchp_pkg::CCR_RST;
  endproperty
  a_reset_pin: assert property (p_reset_pin) else $error("reset pin state wrong");
  property p_dma_request_out_idle;
    (!command_control_out[cchp_pkg::CCR_CDM] && !(command_control_out[cchp_pkg::CCR_DDM]
      && data_xfer_cmd_in)) [*2] |-> dma_request_n_out;
  endproperty
  a_dma_request_out_idle: assert property (p_dma_request_out_idle) else $error("dma request without mode");
  property p_done_stop;
    (!dma_done_n_in) [*4] |=> !command_control_out[cchp_pkg::CCR_CDM];
  endproperty
  a_done_stop: assert property (p_done_stop) else $error("done left command dma on");
endmodule // cchp_host_port_props

bind cchp_host_port cchp_host_port_props u_props (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
  .reset_in_n(reset_in_n), .chip_select_n_in(chip_select_n_in), .dma_grant_n_in(dma_grant_n_in),
  .dma_done_n_in(dma_done_n_in), .data_xfer_cmd_in(data_xfer_cmd_in), .data_out(data_out),
  .data_lo_oe_n_out(data_lo_oe_n_out), .data_hi_oe_n_out(data_hi_oe_n_out),
  .transfer_ack_oe_n_out(transfer_ack_oe_n_out), .irq_oe_n_out(irq_oe_n_out),
  .dma_request_n_out(dma_request_n_out), .halt_out(halt_out), .abort_out(abort_out),
  .display_run_out(display_run_out), .master_slave_out(master_slave_out), .bus16_out(bus16_out),
  .command_control_out(command_control_out), .frame_mem_oe_n_out(frame_mem_oe_n_out),
  .hsync_n_out(hsync_n_out));

// >>> verif/cchp_host_model.sv
// Purpose: host processor and dma controller on the bus pins
// Assumes: pins change at the falling edge, except data, which flips right after the rising edge that shows ack released
// Notes: hang flags an ack that never came or was never released
`timescale 1ns/1ps
module cchp_host_model (
  // clock
  input wire logic core_clk_in,
  // bus pins
  output logic chip_select_n_out,
  output logic register_select_out,
  output logic read_write_out,
  output logic [15:0] data_out,
  output logic dma_grant_n_out,
  input wire logic transfer_ack_oe_n_in,
  input wire logic [15:0] data_in
);
  logic hang;
  // ------------------------------------------------------------
  // bus cycles
  // ------------------------------------------------------------
  // pins idle from time zero
  initial
  begin
    chip_select_n_out = 1'b1;
    dma_grant_n_out = 1'b1;
    register_select_out = 1'b0;
    read_write_out = 1'b1;
    data_out = 16'h5a5a;
    hang = 1'b0;
  end
  task automatic strap(input logic v);
    @(negedge core_clk_in);
    dma_grant_n_out = v;
  endtask
  // one complete cycle, held until ack seen
  task automatic access(input logic dma, input logic rs, input logic rd, input logic [15:0] wd,
                        output logic [15:0] rdat);
    int n;
    @(negedge core_clk_in);
    register_select_out = rs;
    read_write_out = dma ? !rd : rd;
    data_out = rd ? ~data_out : wd;
    if (dma)
      dma_grant_n_out = 1'b0;
    else
      chip_select_n_out = 1'b0;
    n = 0;
    do
    begin
      @(posedge core_clk_in);
      n++;
    end while (transfer_ack_oe_n_in !== 1'b0 && n < 40);
    hang = hang | (n >= 40);
    rdat = data_in;
    // write data kept past select end
    @(negedge core_clk_in);
    chip_select_n_out = 1'b1;
    dma_grant_n_out = 1'b1;
    n = 0;
    while (transfer_ack_oe_n_in !== 1'b1 && n < 40)
    begin
      @(posedge core_clk_in);
      n++;
    end
    hang = hang | (n >= 40);
    data_out = ~data_out; // released lines do not keep the value
    repeat (2) @(negedge core_clk_in);
  endtask
endmodule // cchp_host_model

// >>> verif/crt_ctrl_host_bus_port_test.sv
// Purpose: self-checking bench of the host bus port
// Assumes: host model drives bus pins, bench drives the rest
// Notes: random data from an lfsr seeded with a fixed value
`timescale 1ns/1ps
module crt_ctrl_host_bus_port_test;
  logic core_clk_in, sys_rst_in, reset_in_n, cs_n, rs, rw, grant_n, ack_n, xfer, rdy, run, b16, hs_n;
  logic lo_oe_n, hi_oe_n, irq_n, dma_request_out_n, halt, abort, ms, fm_oe_n;
  logic done_n = 1'b1;
  logic core_hs_n = 1'b1;
  logic [7:0] ev = 8'h00;
  logic [7:0] refresh = 8'h00;
  logic [15:0] wdata, dout, fm_ad, command_control_register, rd;
  logic [15:0] words [3];
  logic [31:0] seed = 32'haa4c;
  int miscompares, tests_run;

  cchp_host_port u_dut (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .reset_in_n(reset_in_n),
    .chip_select_n_in(cs_n), .register_select_in(rs), .read_write_in(rw), .data_in(wdata), .data_out(dout),
    .data_lo_oe_n_out(lo_oe_n), .data_hi_oe_n_out(hi_oe_n), .transfer_ack_oe_n_out(ack_n),
    .irq_oe_n_out(irq_n), .dma_grant_n_in(grant_n), .dma_done_n_in(done_n), .dma_request_n_out(dma_request_out_n),
    .status_event_in(ev), .data_xfer_cmd_in(xfer), .dma_ready_in(rdy), .core_hsync_n_in(core_hs_n),
    .refresh_addr_in(refresh), .halt_out(halt), .abort_out(abort), .display_run_out(run),
    .master_slave_out(ms), .bus16_out(b16), .command_control_out(command_control_register), .frame_mem_addr_data_out(fm_ad),
    .frame_mem_oe_n_out(fm_oe_n), .hsync_n_out(hs_n));
  cchp_host_model u_host (.core_clk_in(core_clk_in), .chip_select_n_out(cs_n), .register_select_out(rs),
    .read_write_out(rw), .data_out(wdata), .dma_grant_n_out(grant_n), .transfer_ack_oe_n_in(ack_n),
    .data_in(dout));

  // ------------------------------------------------------------
  // clock, random core inputs, helpers
  // ------------------------------------------------------------
  initial
  begin
    core_clk_in = 1'b0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // fresh random core inputs every falling edge
  always @(negedge core_clk_in)
  begin
    seed <= lfsr(seed);
    refresh <= seed[7:0];
    core_hs_n <= seed[8];
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one bus cycle; a lost ack ends the run
  task automatic bus(input logic dma, input logic r_s, input logic r_d, input logic [15:0] wd);
    u_host.access(dma, r_s, r_d, wd, rd);
    if (u_host.hang)
    begin
      miscompares++;
      test_done();
    end
  endtask
  task automatic set_ar(input logic [7:0] a);
    bus(1'b0, 1'b0, 1'b0, {8'h00, a});
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    sys_rst_in = 1'b1;
    reset_in_n = 1'b1;
    xfer = 1'b0;
    rdy = 1'b0;
    miscompares = 0;
    tests_run = 0;
    idle(5);
    sys_rst_in = 1'b0;
    idle(4);
    check("bus16", b16, 16'h1);
    check("halt", halt, 16'h0);
    bus(1'b0, 1'b0, 1'b1, 16'h0);
    check("status", rd & 16'h00ff, {8'h00, cchp_pkg::STAT_RST});
    set_ar(cchp_pkg::CCR_IDX);
    bus(1'b0, 1'b1, 1'b1, 16'h0);
    check("ccr", rd, cchp_pkg::CCR_RST);
    set_ar(cchp_pkg::OMR_IDX);
    bus(1'b0, 1'b1, 1'b0, 16'h0003);
    check("refresh", fm_ad, 16'({8'h00, refresh} << 3));
    bus(1'b0, 1'b1, 1'b0, 16'h4003);
    check("run", run, 16'h1);
    check("hsync", hs_n, core_hs_n);
    // masked then enabled condition, cleared by status read
    set_ar(cchp_pkg::CCR_IDX);
    bus(1'b0, 1'b1, 1'b0, 16'h0004);
    ev = 8'h08;
    idle(1);
    ev = 8'h00;
    idle(3);
    check("irq masked", irq_n, 16'h1);
    ev = 8'h04;
    idle(1);
    ev = 8'h00;
    idle(3);
    check("irq", irq_n, 16'h0);
    bus(1'b0, 1'b0, 1'b1, 16'h0);
    check("events", rd & 16'h000c, 16'h000c);
    idle(3);
    check("irq clear", irq_n, 16'h1);
    // command dma, then done from the controller
    bus(1'b0, 1'b1, 1'b0, 16'h1000);
    rdy = 1'b1;
    idle(4);
    check("cmd dma_request_out", dma_request_out_n, 16'h0);
    bus(1'b1, 1'b0, 1'b0, {seed[15:8], cchp_pkg::CCR_IDX});
    done_n = 1'b0;
    idle(4);
    done_n = 1'b1;
    idle(3);
    check("cdm cleared", command_control_register[cchp_pkg::CCR_CDM], 16'h0);
    check("dma_request_out off", dma_request_out_n, 16'h1);
    bus(1'b0, 1'b1, 1'b0, 16'h0c00);
    xfer = 1'b1;
    idle(4);
    check("data dma_request_out", dma_request_out_n, 16'h0);
    xfer = 1'b0;
    // word bus: upper range advances by two, lower does not
    // whole words only
    set_ar(8'h80);
    for (int i = 0; i < 3; i++)
    begin
      words[i] = seed[15:0];
      bus(1'b0, 1'b1, 1'b0, words[i]);
    end
    set_ar(8'h7e);
    bus(1'b0, 1'b1, 1'b0, 16'h1234);
    bus(1'b0, 1'b1, 1'b0, 16'hbeef);
    set_ar(8'h7e);
    bus(1'b0, 1'b1, 1'b1, 16'h0);
    check("no advance", rd, 16'hbeef);
    set_ar(8'h80);
    for (int i = 0; i < 3; i++)
    begin
      bus(1'b0, 1'b1, 1'b1, 16'h0);
      check("word read", rd, words[i]);
    end
    // reset pin with grant low: byte bus, store kept
    u_host.strap(1'b0);
    reset_in_n = 1'b0;
    idle(5);
    check("pin halt", {b16, ms, run, abort, halt}, 16'h0003);
    u_host.strap(1'b1);
    reset_in_n = 1'b1;
    idle(4);
    check("byte bus", b16, 16'h0);
    check("step kept", fm_ad, 16'({8'h00, refresh} << 3));
    bus(1'b0, 1'b0, 1'b1, 16'h0);
    check("status pin", rd & 16'h00ff, {8'h00, cchp_pkg::STAT_RST});
    set_ar(8'h80);
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b0, 1'b1, 1'b1, 16'h0);
      check("byte read", rd & 16'h00ff, {8'h00, i[0] ? words[i / 2][7:0] : words[i / 2][15:8]});
    end
    test_done();
  end
endmodule // crt_ctrl_host_bus_port_test
